// [indexer_motion_sequencer.sv]
// Summary of operation
// [RULE_01] Start rising during a motion is ignored and starts nothing.
// [RULE_02] Master raises start again only after movement done is set.
// [RULE_03] Station above division count minus one raises the next-station warning.
// [RULE_04] Delay after in-position, then torque limit switches to limit two.
// [RULE_05] From power-on, in-position shows when position lies in a station range.
// [RULE_06] Master updates station and speed words well ahead of start.
// [RULE_07] Direct speed needs two stations; speed word plus table one ramps.
// [RULE_08] Mode select one high and two low selects manual mode.
// [RULE_09] Manual mode ignores station select bits and speed select bits.
// [RULE_10] Jog kind parameter picks indexer jog or plain jog.
// [RULE_11] Both jogs run at table one speed and ramps while start high.
// [RULE_12] Indexer jog stops at first station reachable when start falls.
// [RULE_13] Plain jog decelerates to stop anywhere when start falls.
// [RULE_14] Station direction sets numbering and jog direction; resets to 0.
// [RULE_15] Indexer behaviour runs only when operation select leading digit is 1.
// [RULE_16] Start before any home return is refused with the home alarm.
// [RULE_17] Movement done clears when a motion is accepted, sets when it ends.

`include "indexer_cfg.svh"
module indexer_motion_sequencer #(
  parameter int unsigned TL_UNIT_CYCLES = `TL_UNIT_CYCLES,
  parameter int unsigned DELAY_W = 16
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Remote input bits from the master
  input wire logic motion_start_bit_in,
  input wire logic op_mode_select_1_in,
  input wire logic op_mode_select_2_in,
  input wire logic [`STATION_W-1:0] next_station_select_bits_in,
  input wire logic [`TABLE_W-1:0] speed_select_bits_in,
  input wire logic direct_speed_select_in,
  // Remote word registers from the master
  input wire logic [`WORD_W-1:0] next_station_word_in,
  input wire logic [`WORD_W-1:0] table_or_speed_word_in,
  // Drive parameters
  input wire logic [`WORD_W-1:0] operation_select_param_in,
  input wire logic [`STATION_W-1:0] station_division_count_in,
  input wire logic [DELAY_W-1:0] torque_limit_delay_param_in,
  input wire logic [`WORD_W-1:0] internal_torque_limit_one_in,
  input wire logic [`WORD_W-1:0] internal_torque_limit_two_in,
  input wire logic station_direction_param_in,
  input wire logic jog_kind_param_in,
  input wire logic two_stations_occupied_in,
  // Servo loop feedback
  input wire logic home_return_done_in,
  input wire logic position_in_station_range_in,
  input wire logic motion_finished_in,
  // Motion request and torque limit to the servo loop
  output indexer_pkg::motion_cmd_t motion_cmd_out,
  output logic [`WORD_W-1:0] torque_limit_out,
  // Status to the master
  output indexer_pkg::drive_status_t status_out
);
  import indexer_pkg::*;

  // Refused at elaboration: a zero prescaler never ends a unit, and wide delays waste area
  if (TL_UNIT_CYCLES < 1) begin
    $error("indexer_motion_sequencer: prescaler count must be at least one");
  end
  if (DELAY_W < 1 || DELAY_W > 24) begin
    $error("indexer_motion_sequencer: delay width out of range");
  end

  seq_state_t state;
  logic start_q;
  logic start_rise;
  logic start_fall;
  logic manual_mode;
  logic auto_mode;
  logic indexer_en;
  logic dir;
  logic [`STATION_W-1:0] req_station;
  logic station_bad;
  logic accept;
  logic [$clog2(TL_UNIT_CYCLES+1)-1:0] unit_cnt;
  logic [DELAY_W-1:0] delay_cnt;
  logic delay_done;
  logic in_pos_q;
  logic done_flag;
  logic warn_flag;
  logic alarm_flag;
  logic in_pos_flag;

  assign start_rise = motion_start_bit_in & ~start_q;
  assign start_fall = ~motion_start_bit_in & start_q;

  // Leading digit gates every new start, the warning, the alarm and in-position
  assign indexer_en = operation_select_param_in[`OPSEL_DIGIT_MSB:`OPSEL_DIGIT_LSB]
                      == `OPSEL_INDEXER; // [RULE_15]

  assign manual_mode = op_mode_select_1_in & ~op_mode_select_2_in; // [RULE_08]
  // Both selects low is home return, handled elsewhere
  assign auto_mode = op_mode_select_2_in;

  // Mode one takes select bits, mode two takes the station word
  always_comb begin
    if (op_mode_select_1_in) begin
      req_station = next_station_word_in[`STATION_W-1:0];
    end else begin
      req_station = next_station_select_bits_in;
    end
  end

  // Count zero would allow no station at all, so it is treated as all bad
  assign station_bad = auto_mode &&
                       ({1'b0, req_station} + 9'h001 > {1'b0, station_division_count_in}); // [RULE_03]

  // A new start is only heard while idle; during motion it is dropped
  assign accept = indexer_en && start_rise && state == ST_IDLE
                  && home_return_done_in && !(auto_mode && station_bad)
                  && (auto_mode || manual_mode); // [RULE_01] [RULE_16]

  // Idle level of start is low, so no false edge follows reset
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      start_q <= 1'b0;
    end else begin
      start_q <= motion_start_bit_in;
    end
  end

  // Direction parameter is sampled so it has a defined value from reset
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      dir <= `DIR_RESET; // [RULE_14]
    end else begin
      dir <= station_direction_param_in; // [RULE_14]
    end
  end

  // Sequencer state
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state <= ST_IDLE;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (accept && manual_mode) begin
            state <= ST_JOG;
          end else if (accept) begin
            state <= ST_INDEX;
          end
        end
        ST_INDEX: begin
          if (motion_finished_in) begin
            state <= ST_IDLE;
          end
        end
        ST_JOG: begin
          if (start_fall) begin
            state <= ST_JOG_STOP;
          end
        end
        ST_JOG_STOP: begin
          if (motion_finished_in) begin
            state <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // Motion request toward the servo loop
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      motion_cmd_out <= '0;
    end else if (state == ST_IDLE && accept && manual_mode) begin
      // Select bits are not looked at in manual mode
      motion_cmd_out.kind <= CMD_JOG; // [RULE_09] [RULE_11]
      motion_cmd_out.station <= '0;
      motion_cmd_out.use_speed_word <= 1'b0;
      motion_cmd_out.speed <= '0;
      motion_cmd_out.table_sel <= `JOG_TABLE; // [RULE_11]
      motion_cmd_out.dir <= dir; // [RULE_14]
    end else if (state == ST_IDLE && accept) begin
      motion_cmd_out.kind <= CMD_INDEX;
      motion_cmd_out.station <= req_station;
      motion_cmd_out.dir <= dir; // [RULE_14]
      if (!op_mode_select_1_in) begin
        // Speed bits are latched here only, changes while turning are ignored
        motion_cmd_out.use_speed_word <= 1'b0;
        motion_cmd_out.speed <= '0;
        motion_cmd_out.table_sel <= speed_select_bits_in;
      end else if (direct_speed_select_in && two_stations_occupied_in) begin
        motion_cmd_out.use_speed_word <= 1'b1; // [RULE_07]
        motion_cmd_out.speed <= table_or_speed_word_in; // [RULE_07]
        motion_cmd_out.table_sel <= `JOG_TABLE; // [RULE_07]
      end else begin
        motion_cmd_out.use_speed_word <= 1'b0;
        motion_cmd_out.speed <= '0;
        motion_cmd_out.table_sel <= table_or_speed_word_in[`TABLE_W-1:0];
      end
    end else if (state == ST_JOG && start_fall) begin
      if (jog_kind_param_in == `JOG_KIND_INDEXER) begin
        motion_cmd_out.kind <= CMD_STOP_STATION; // [RULE_10] [RULE_12]
      end else begin
        motion_cmd_out.kind <= CMD_STOP_FREE; // [RULE_10] [RULE_13]
      end
    end else if ((state == ST_INDEX || state == ST_JOG_STOP) && motion_finished_in) begin
      motion_cmd_out.kind <= CMD_NONE;
    end
  end

  // Movement done flag
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      done_flag <= 1'b1;
    end else if (state == ST_IDLE && accept) begin
      done_flag <= 1'b0; // [RULE_17]
    end else if ((state == ST_INDEX || state == ST_JOG_STOP) && motion_finished_in) begin
      done_flag <= 1'b1; // [RULE_17] [RULE_02]
    end
  end

  // Warning holds until the next start that names a good station
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      warn_flag <= 1'b0;
    end else if (indexer_en && start_rise && state == ST_IDLE && auto_mode) begin
      warn_flag <= station_bad; // [RULE_03]
    end
  end

  // Alarm stays up until a home return has been completed
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      alarm_flag <= 1'b0;
    end else if (indexer_en && start_rise && !home_return_done_in
                 && (auto_mode || manual_mode)) begin
      alarm_flag <= 1'b1; // [RULE_16]
    end else if (home_return_done_in) begin
      alarm_flag <= 1'b0;
    end
  end

  // In-position follows the loop's station window whenever no motion runs and the leading digit enables the indexer
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      in_pos_q <= 1'b0;
    end else begin
      in_pos_q <= indexer_en && state == ST_IDLE
                  && position_in_station_range_in; // [RULE_05]
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      in_pos_flag <= 1'b0;
    end else begin
      in_pos_flag <= in_pos_q; // [RULE_05]
    end
  end

  // Flags sit in their own registers so every field has one writer
  assign status_out = '{
    movement_done_flag: done_flag,
    in_position_flag: in_pos_flag,
    next_station_warning: warn_flag,
    home_incomplete_alarm: alarm_flag
  };

  // Delay runs in whole units so a short prescaler serves a long delay
  // Any drop of in-position restarts the whole delay
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      unit_cnt <= '0;
      delay_cnt <= '0;
    end else if (!in_pos_q || delay_done) begin
      unit_cnt <= '0;
      delay_cnt <= '0;
    end else if (unit_cnt == $bits(unit_cnt)'(TL_UNIT_CYCLES - 1)) begin
      unit_cnt <= '0;
      delay_cnt <= delay_cnt + 1'b1; // [RULE_04]
    end else begin
      unit_cnt <= unit_cnt + 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      delay_done <= 1'b0;
    end else if (!in_pos_q) begin
      delay_done <= 1'b0;
    end else if (delay_cnt >= torque_limit_delay_param_in) begin
      delay_done <= 1'b1; // [RULE_04]
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      torque_limit_out <= '0;
    end else if (delay_done && in_pos_q) begin
      torque_limit_out <= internal_torque_limit_two_in; // [RULE_04]
    end else begin
      torque_limit_out <= internal_torque_limit_one_in;
    end
  end

endmodule

// [indexer_cfg.svh]
`ifndef INDEXER_CFG_SVH
`define INDEXER_CFG_SVH

// Clock and delay timing
`define CLK_PERIOD_NS 50
`define TL_DELAY_UNIT_NS 1000000
`define TL_UNIT_CYCLES (`TL_DELAY_UNIT_NS / `CLK_PERIOD_NS)

// Parameter field positions and values
`define OPSEL_DIGIT_MSB 15
`define OPSEL_DIGIT_LSB 12
`define OPSEL_INDEXER 4'h1
`define JOG_KIND_INDEXER 1'b0
`define DIR_RESET 1'b0

// Point table entry used by jog and direct speed
`define JOG_TABLE 3'h1

// Widths
`define STATION_W 8
`define WORD_W 16
`define TABLE_W 3

`endif

// [indexer_pkg.sv]
`include "indexer_cfg.svh"

package indexer_pkg;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_INDEX = 2'b01,
    ST_JOG = 2'b10,
    ST_JOG_STOP = 2'b11
  } seq_state_t;

  typedef enum logic [2:0] {
    CMD_NONE = 3'b000,
    CMD_INDEX = 3'b001,
    CMD_JOG = 3'b010,
    CMD_STOP_STATION = 3'b011,
    CMD_STOP_FREE = 3'b100
  } cmd_kind_t;

  // Motion request handed to the servo loop
  typedef struct packed {
    cmd_kind_t kind;
    logic [`STATION_W-1:0] station;
    logic use_speed_word;
    logic [`WORD_W-1:0] speed;
    logic [`TABLE_W-1:0] table_sel;
    logic dir;
  } motion_cmd_t;

  // Status seen by the fieldbus master
  typedef struct packed {
    logic movement_done_flag;
    logic in_position_flag;
    logic next_station_warning;
    logic home_incomplete_alarm;
  } drive_status_t;

endpackage

// [indexer_props.sv]
`include "indexer_cfg.svh"
module indexer_props (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Inputs watched
  input wire logic motion_start_bit_in,
  input wire logic op_mode_select_1_in,
  input wire logic op_mode_select_2_in,
  input wire logic home_return_done_in,
  input wire logic position_in_station_range_in,
  input wire logic motion_finished_in,
  input wire logic jog_kind_param_in,
  input wire logic [`WORD_W-1:0] next_station_word_in,
  input wire logic [`WORD_W-1:0] operation_select_param_in,
  input wire logic [`WORD_W-1:0] internal_torque_limit_one_in,
  input wire logic [`STATION_W-1:0] station_division_count_in,
  // Outputs watched
  input wire indexer_pkg::motion_cmd_t motion_cmd_out,
  input wire logic [`WORD_W-1:0] torque_limit_out,
  input wire indexer_pkg::drive_status_t status_out
);
  timeunit 1ns;
  timeprecision 1ns;
  import indexer_pkg::*;
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);
  logic idle;
  logic opsel_on;
  logic en;
  // Answer may land one or two edges after the taken edge
  assign idle = motion_cmd_out.kind == CMD_NONE && status_out.movement_done_flag;
  assign opsel_on = operation_select_param_in[`OPSEL_DIGIT_MSB:`OPSEL_DIGIT_LSB] == `OPSEL_INDEXER;
  assign en = idle && opsel_on;
  busy_ignore_a: assert property (
    motion_cmd_out.kind != CMD_NONE && !motion_finished_in && $rose(motion_start_bit_in)
    |=> $stable(motion_cmd_out)) else $error("start taken while busy");
  warn_raise_a: assert property (
    en && home_return_done_in && op_mode_select_1_in && op_mode_select_2_in
    && $rose(motion_start_bit_in) && next_station_word_in[7:0] >= station_division_count_in
    |-> ##[1:2] status_out.next_station_warning) else $error("no station warning");
  tl_hold_a: assert property (
    $rose(status_out.in_position_flag) |-> torque_limit_out == internal_torque_limit_one_in)
    else $error("torque limit switched early");
  inpos_follow_a: assert property (
    (opsel_on && motion_cmd_out.kind == CMD_NONE && position_in_station_range_in) [*4]
    |-> status_out.in_position_flag) else $error("in position missing");
  jog_start_a: assert property (
    en && home_return_done_in && op_mode_select_1_in && !op_mode_select_2_in
    && $rose(motion_start_bit_in) |-> ##[1:2] motion_cmd_out.kind == CMD_JOG
    && motion_cmd_out.table_sel == `JOG_TABLE) else $error("jog not started");
  jog_stop_a: assert property (
    motion_cmd_out.kind == CMD_JOG && $fell(motion_start_bit_in) |-> ##[1:2]
    motion_cmd_out.kind == (jog_kind_param_in ? CMD_STOP_FREE : CMD_STOP_STATION))
    else $error("wrong jog stop");
  finish_done_a: assert property (
    motion_cmd_out.kind inside {CMD_INDEX, CMD_STOP_STATION, CMD_STOP_FREE} && motion_finished_in
    |-> ##[1:2] idle) else $error("done flag not set");
  home_alarm_a: assert property (
    en && !home_return_done_in && (op_mode_select_1_in || op_mode_select_2_in)
    && $rose(motion_start_bit_in) |-> ##[1:2] status_out.home_incomplete_alarm
    && motion_cmd_out.kind == CMD_NONE) else $error("home alarm missing");
  opsel_gate_a: assert property (
    operation_select_param_in[15:12] != 4'h1 && motion_cmd_out.kind == CMD_NONE
    |=> motion_cmd_out.kind == CMD_NONE) else $error("motion while disabled");
  cover property ($rose(status_out.next_station_warning));
  cover property (motion_cmd_out.kind == CMD_STOP_FREE);
  cover property ($rose(status_out.home_incomplete_alarm));
endmodule
bind indexer_motion_sequencer indexer_props chk_u (.clk_in, .rst_n_in, .motion_start_bit_in,
  .op_mode_select_1_in, .op_mode_select_2_in, .home_return_done_in, .motion_finished_in,
  .position_in_station_range_in, .jog_kind_param_in, .next_station_word_in, .status_out,
  .operation_select_param_in, .internal_torque_limit_one_in, .station_division_count_in,
  .motion_cmd_out, .torque_limit_out);

// [servo_model.sv]
module servo_model #(
  parameter int LAT = 5
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Command in, feedback out
  input wire indexer_pkg::motion_cmd_t cmd_in,
  output logic finished_out,
  output logic range_out
);
  timeunit 1ns;
  timeprecision 1ns;
  import indexer_pkg::*;
  logic [7:0] cnt;
  logic moving;
  assign moving = cmd_in.kind inside {CMD_INDEX, CMD_STOP_STATION, CMD_STOP_FREE};
  // Sits on a station whenever nothing is commanded
  assign range_out = cmd_in.kind == CMD_NONE;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt <= 8'h00;
      finished_out <= 1'b0;
    end else begin
      cnt <= (moving && !finished_out) ? cnt + 8'h01 : 8'h00;
      finished_out <= moving && cnt == 8'(LAT);
    end
  end
endmodule

// [tb_top.sv]
`include "indexer_cfg.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import indexer_pkg::*;
  logic clk_in, rst_n_in, motion_start_bit_in, op_mode_select_1_in, op_mode_select_2_in;
  logic direct_speed_select_in, station_direction_param_in, jog_kind_param_in;
  logic two_stations_occupied_in, home_return_done_in;
  logic position_in_station_range_in, motion_finished_in;
  logic [7:0] next_station_select_bits_in, station_division_count_in;
  logic [2:0] speed_select_bits_in;
  logic [15:0] next_station_word_in, table_or_speed_word_in, operation_select_param_in;
  logic [15:0] torque_limit_delay_param_in, torque_limit_out;
  logic [15:0] internal_torque_limit_one_in, internal_torque_limit_two_in;
  motion_cmd_t motion_cmd_out;
  drive_status_t status_out;
  int err_total, cmp_count, cycles;
  indexer_motion_sequencer #(.TL_UNIT_CYCLES(4)) dut_u (.clk_in, .rst_n_in,
    .motion_start_bit_in, .op_mode_select_1_in, .op_mode_select_2_in,
    .next_station_select_bits_in, .speed_select_bits_in, .direct_speed_select_in,
    .next_station_word_in, .table_or_speed_word_in, .operation_select_param_in,
    .station_division_count_in, .torque_limit_delay_param_in,
    .internal_torque_limit_one_in, .internal_torque_limit_two_in,
    .station_direction_param_in, .jog_kind_param_in, .two_stations_occupied_in,
    .home_return_done_in, .position_in_station_range_in, .motion_finished_in,
    .motion_cmd_out, .torque_limit_out, .status_out);
  servo_model #(.LAT(12)) servo_u (.clk_in, .rst_n_in, .cmd_in(motion_cmd_out),
    .finished_out(motion_finished_in), .range_out(position_in_station_range_in));
  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      err_total++;
      end_sim();
    end
  end
  task automatic chk(input string n, input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s expected %0h seen %0h", n, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic go(input logic v);
    @(posedge clk_in);
    motion_start_bit_in <= v;
    tick(2);
  endtask
  task automatic wait_done;
    int n = 0;
    while (status_out.movement_done_flag !== 1'b1 && n < 50) begin
      tick(1);
      n++;
    end
    chk("done", status_out.movement_done_flag, 1'b1);
  endtask
  task automatic end_sim;
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic t_torque;
    tick(4);
    chk("in_pos", status_out.in_position_flag, 1'b1);
    chk("tl_one", torque_limit_out, internal_torque_limit_one_in);
    tick(6);
    chk("tl_wait", torque_limit_out, internal_torque_limit_one_in);
    tick(12);
    chk("tl_two", torque_limit_out, internal_torque_limit_two_in);
  endtask
  task automatic t_home;
    go(1'b1);
    chk("alarm", status_out.home_incomplete_alarm, 1'b1);
    chk("no_move", motion_cmd_out.kind, CMD_NONE);
    go(1'b0);
    home_return_done_in <= 1'b1;
    tick(3);
    chk("alarm_clr", status_out.home_incomplete_alarm, 1'b0);
  endtask
  task automatic t_index;
    next_station_select_bits_in <= 8'h03;
    speed_select_bits_in <= 3'h5;
    go(1'b1);
    chk("idx", motion_cmd_out.kind, CMD_INDEX);
    chk("idx_st", motion_cmd_out.station, 8'h03);
    chk("idx_tbl", motion_cmd_out.table_sel, 3'h5);
    chk("busy", status_out.movement_done_flag, 1'b0);
    next_station_select_bits_in <= 8'h01;
    go(1'b0);
    go(1'b1);
    chk("ignored", motion_cmd_out.station, 8'h03);
    go(1'b0);
    wait_done();
    chk("idle", motion_cmd_out.kind, CMD_NONE);
  endtask
  task automatic t_warn;
    op_mode_select_1_in <= 1'b1;
    next_station_word_in <= 16'h0004;
    table_or_speed_word_in <= 16'h0002;
    go(1'b1);
    chk("warn", status_out.next_station_warning, 1'b1);
    chk("warn_kind", motion_cmd_out.kind, CMD_NONE);
    go(1'b0);
    next_station_word_in <= 16'h0003;
    go(1'b1);
    chk("warn_clr", status_out.next_station_warning, 1'b0);
    chk("word_tbl", motion_cmd_out.table_sel, 3'h2);
    go(1'b0);
    wait_done();
  endtask
  task automatic t_direct;
    direct_speed_select_in <= 1'b1;
    two_stations_occupied_in <= 1'b1;
    table_or_speed_word_in <= 16'h0bb8;
    go(1'b1);
    chk("spd_use", motion_cmd_out.use_speed_word, 1'b1);
    chk("spd", motion_cmd_out.speed, 16'h0bb8);
    chk("spd_tbl", motion_cmd_out.table_sel, `JOG_TABLE);
    go(1'b0);
    wait_done();
    two_stations_occupied_in <= 1'b0;
    go(1'b1);
    chk("spd_one", motion_cmd_out.use_speed_word, 1'b0);
    go(1'b0);
    wait_done();
    direct_speed_select_in <= 1'b0;
  endtask
  task automatic t_jog(input logic k);
    op_mode_select_2_in <= 1'b0;
    jog_kind_param_in <= k;
    station_direction_param_in <= k;
    next_station_select_bits_in <= 8'hff;
    speed_select_bits_in <= 3'h7;
    go(1'b1);
    chk("jog", motion_cmd_out.kind, CMD_JOG);
    chk("jog_tbl", motion_cmd_out.table_sel, `JOG_TABLE);
    chk("jog_dir", motion_cmd_out.dir, k);
    go(1'b0);
    chk("stop", motion_cmd_out.kind, k ? CMD_STOP_FREE : CMD_STOP_STATION);
    wait_done();
  endtask
  initial begin
    {rst_n_in, motion_start_bit_in, op_mode_select_1_in, direct_speed_select_in} = '0;
    {station_direction_param_in, jog_kind_param_in, two_stations_occupied_in} = '0;
    {home_return_done_in, next_station_select_bits_in, speed_select_bits_in} = '0;
    {next_station_word_in, table_or_speed_word_in} = '0;
    op_mode_select_2_in = 1'b1;
    operation_select_param_in = 16'h1000;
    station_division_count_in = 8'h04;
    torque_limit_delay_param_in = 16'h0003;
    internal_torque_limit_one_in = 16'h0064;
    internal_torque_limit_two_in = 16'h0032;
    repeat (6) @(posedge clk_in);
    rst_n_in <= 1'b1;
    tick(1);
    chk("done_rst", status_out.movement_done_flag, 1'b1);
    chk("dir_rst", motion_cmd_out.dir, `DIR_RESET);
    t_torque();
    $display("torque test over");
    t_home();
    $display("home test over");
    t_index();
    $display("index test over");
    t_warn();
    $display("warning test over");
    t_direct();
    $display("direct speed test over");
    for (int k = 0; k < 2; k++) t_jog(k[0]);
    $display("jog tests over");
    operation_select_param_in <= 16'h2000;
    go(1'b1);
    chk("opsel_off", motion_cmd_out.kind, CMD_NONE);
    $display("disable test over");
    end_sim();
  end
endmodule
